// ===== tb/interrupt_trap_status_switch_bench.sv
`timescale 1ns/1ns
module interrupt_trap_status_switch_bench;
    import itss_pkg::*;
    logic        sys_clk_in, rst_in, nmi_req_in, nvi_req_in, vi_req_in, insn_end_in;
    logic        priv_op_in, syscall_in, ldps_in, tset_in, ext_op_in, ext_wr_in;
    logic        psap_wr_in, bus_ready_in, bus_strobe_out, bus_we_out, bus_lock_out;
    logic        normal_mode_out, busy_out, sp_invalid_out, tset_old_out, ps_load_out;
    logic [15:0] ldps_addr_in, tset_addr_in, ext_addr_in, ext_data_in, psap_data_in;
    logic [15:0] bus_rdata_in, bus_wdata_out, cur_pc_in, new_pc_out, sp_out, ssp;
    logic [7:0]  cur_flags_in, new_flags_out, ctrl_out;
    logic [3:0]  sp_reg_sel_in, bus_stat_out;
    logic [6:0]  cur_seg_in;
    logic [22:0] bus_addr_out;
    int          n_mismatch, n_compared, n_load, ix;

    itss_top u_itss_top (
        .sys_clk_in, .rst_in, .nmi_req_in, .nvi_req_in, .vi_req_in, .insn_end_in,
        .priv_op_in, .syscall_in, .ldps_in, .ldps_addr_in, .tset_in, .tset_addr_in,
        .ext_op_in, .ext_wr_in, .ext_addr_in, .ext_data_in, .sp_reg_sel_in,
        .cur_flags_in, .cur_pc_in, .cur_seg_in, .psap_wr_in, .psap_data_in,
        .bus_ready_in, .bus_rdata_in, .bus_strobe_out, .bus_we_out, .bus_stat_out,
        .bus_addr_out, .bus_wdata_out, .bus_lock_out, .normal_mode_out, .busy_out,
        .sp_invalid_out, .tset_old_out, .ps_load_out, .new_flags_out, .ctrl_out,
        .new_pc_out, .sp_out
    );
    itss_bus_model u_itss_bus_model (
        .sys_clk_in, .rst_in, .strobe_in(bus_strobe_out), .we_in(bus_we_out),
        .stat_in(bus_stat_out), .addr_in(bus_addr_out), .wdata_in(bus_wdata_out),
        .lock_in(bus_lock_out), .ready_out(bus_ready_in), .rdata_out(bus_rdata_in)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        if (ps_load_out === 1'b1)
            n_load <= n_load + 1;
    end

    task automatic conclude;
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // Bounded wait; a hung sequencer ends the run
    task automatic pulse(ref logic s);
        int k;
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(2);
        for (k = 0; k < 300 && busy_out !== 1'b0; k++)
            step(1);
        if (k == 300) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        u_itss_bus_model.mem[a[7:1]] = d;
    endtask
    task automatic chk_rd(input logic [15:0] a);
        chk(u_itss_bus_model.lg[ix][43], 1'b0);
        chk(u_itss_bus_model.lg[ix][38:16], {7'h00, a});
        ix++;
    endtask
    task automatic exc(input logic [3:0] ack, input logic [15:0] pc, cf, why, off);
        logic [15:0] w [3];
        w = '{pc, cf, why};
        if (ack !== ST_IDLE) begin
            chk(u_itss_bus_model.lg[ix][43:39], {1'b0, ack});
            ix++;
        end
        for (int k = 0; k < 3; k++) begin
            chk(u_itss_bus_model.lg[ix][43:39], {1'b1, ST_STACK});
            chk(u_itss_bus_model.lg[ix][38:0], {7'h00, ssp - 16'(2*k+2), w[k]});
            ix++;
        end
        ssp = ssp - 16'h0006;
        chk_rd(16'h0040 + off);
        chk_rd(16'h0042 + off);
    endtask

    task automatic t_reset;
        chk({ctrl_out, normal_mode_out, busy_out, bus_strobe_out}, {CTL_RST, 3'b000});
        chk(sp_out, SP_RST);
        sp_reg_sel_in = 4'h0;
        step(1);
        chk(sp_invalid_out, 1'b1);
        sp_reg_sel_in = 4'h5;
        step(1);
        chk(sp_invalid_out, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_nmi;
        psap_data_in = 16'h0040;
        pulse(psap_wr_in);
        poke(16'h0044, 16'h58A5);
        poke(16'h0046, 16'h1234);
        u_itss_bus_model.vec_val = 16'h00C3;
        cur_pc_in = 16'h0100;
        cur_flags_in = 8'h11;
        nmi_req_in = 1'b1;
        step(4);
        chk(busy_out, 1'b0);
        pulse(insn_end_in);
        nmi_req_in = 1'b0;
        exc(ST_NMI_ACK, 16'h0100, 16'h4011, 16'h00C3, PSA_NMI_OFF);
        chk({ctrl_out, new_flags_out, new_pc_out}, 32'h58A5_1234);
        chk({ps_load_out, sp_out}, {1'b1, ssp});
        $display("test nmi done");
    endtask
    task automatic t_ldps_trap;
        poke(16'h0020, 16'h1866);
        poke(16'h0022, 16'h2000);
        ldps_addr_in = 16'h0020;
        pulse(ldps_in);
        chk_rd(16'h0020);
        chk_rd(16'h0022);
        chk({ctrl_out, new_flags_out, new_pc_out}, 32'h1866_2000);
        chk({normal_mode_out, sp_out}, {1'b1, SP_RST});
        psap_data_in = 16'h0100;
        pulse(psap_wr_in);
        poke(16'h004C, 16'h5800);
        poke(16'h004E, 16'h3000);
        cur_pc_in = 16'h2002;
        cur_flags_in = 8'h66;
        pulse(priv_op_in);
        exc(ST_IDLE, 16'h2002, 16'h1866, WHY_PRIV, PSA_TRAP_OFF);
        chk({normal_mode_out, new_pc_out, sp_out}, {1'b0, 16'h3000, ssp});
        $display("test load status and trap done");
    endtask
    task automatic t_vec;
        poke(16'h0054, 16'h5800);
        poke(16'h0056, 16'h0000);
        poke(16'h005E, 16'h4444);
        poke(16'h0048, 16'h5800);
        poke(16'h004A, 16'h5555);
        u_itss_bus_model.vec_val = 16'h0003;
        u_itss_bus_model.lat = 2;
        cur_pc_in = 16'h3000;
        cur_flags_in = 8'h00;
        vi_req_in = 1'b1;
        nvi_req_in = 1'b1;
        pulse(insn_end_in);
        vi_req_in = 1'b0;
        exc(ST_VI_ACK, 16'h3000, 16'h5800, 16'h0003, PSA_VI_OFF);
        chk_rd(16'h0040 + PSA_JT_OFF + 16'h0006);
        chk(new_pc_out, 16'h4444);
        pulse(insn_end_in);
        nvi_req_in = 1'b0;
        exc(ST_NVI_ACK, 16'h3000, 16'h5800, 16'h0003, PSA_NVI_OFF);
        chk(new_pc_out, 16'h5555);
        u_itss_bus_model.lat = 0;
        $display("test vectored priority done");
    endtask
    task automatic t_sys;
        poke(16'h0050, 16'h5801);
        poke(16'h0052, 16'h6000);
        pulse(ldps_in);
        chk_rd(16'h0020);
        chk_rd(16'h0022);
        cur_pc_in = 16'h2004;
        cur_flags_in = 8'h66;
        pulse(syscall_in);
        exc(ST_IDLE, 16'h2004, 16'h1866, WHY_SYSCALL, PSA_SC_OFF);
        chk({normal_mode_out, ctrl_out, new_pc_out}, {1'b0, 8'h58, 16'h6000});
        $display("test system call done");
    endtask
    task automatic t_tset_ext;
        poke(16'h0030, 16'h8001);
        tset_addr_in = 16'h0030;
        u_itss_bus_model.lat = 3;
        pulse(tset_in);
        chk(u_itss_bus_model.lg[ix][44:43], 2'b10);
        chk(u_itss_bus_model.lg[ix][38:16], 23'h000030);
        ix++;
        chk(u_itss_bus_model.lg[ix][44:43], 2'b11);
        chk(u_itss_bus_model.lg[ix][38:0], 39'h0030_FFFF);
        ix++;
        chk({tset_old_out, bus_lock_out}, 2'b10);
        u_itss_bus_model.lat = 0;
        ext_wr_in = 1'b1;
        ext_addr_in = 16'h0034;
        ext_data_in = 16'hBEEF;
        pulse(ext_op_in);
        chk(u_itss_bus_model.lg[ix][43:0], {1'b1, ST_EPU_DATA, 39'h0034_BEEF});
        ix++;
        ext_wr_in = 1'b0;
        ext_addr_in = 16'h0036;
        pulse(ext_op_in);
        chk(u_itss_bus_model.lg[ix][43:16], {1'b0, ST_EPU_DATA, 23'h000036});
        ix++;
        chk(u_itss_bus_model.n_log, ix);
        chk(n_load, 7);
        for (int k = 0; k < ix; k++)
            chk(u_itss_bus_model.lg[k][38:32], 7'h00);
        $display("test lock and extension done");
    endtask

    initial begin
        {nmi_req_in, nvi_req_in, vi_req_in, insn_end_in, priv_op_in, syscall_in} = '0;
        {ldps_in, tset_in, ext_op_in, ext_wr_in, psap_wr_in} = '0;
        {ldps_addr_in, tset_addr_in, ext_addr_in, ext_data_in, psap_data_in} = '0;
        {cur_pc_in, cur_flags_in, sp_reg_sel_in, cur_seg_in} = '0;
        // Nonzero so a segment leak on the linear variant shows in the log
        cur_seg_in = 7'h55;
        {n_mismatch, n_compared, n_load, ix} = '0;
        ssp = SP_RST;
        rst_in = 1'b1;
        step(4);
        rst_in = 1'b0;
        t_reset();
        t_nmi();
        t_ldps_trap();
        t_vec();
        t_sys();
        t_tset_ext();
        conclude();
    end
endmodule

// ===== tb/itss_bus_model.sv
`timescale 1ns/1ns
// Bus peer: memory, interrupt sources that answer acknowledges, transfer log
module itss_bus_model
    import itss_pkg::*;
(
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             strobe_in,
    input  wire logic             we_in,
    input  wire logic [3:0]       stat_in,
    input  wire logic [LIN_W-1:0] addr_in,
    input  wire logic [15:0]      wdata_in,
    input  wire logic             lock_in,
    output logic                  ready_out,
    output logic [15:0]           rdata_out
);
    // Log entry: lock, we, stat, addr, data
    logic [44:0] lg [0:63];
    logic [15:0] mem [0:127];
    logic [15:0] vec_val;
    int          lat;
    int          cnt;
    int          n_log;
    initial begin
        ready_out = 1'b0;
        rdata_out = 16'h0000;
        vec_val = 16'h0000;
        lat = 0;
        cnt = 0;
        n_log = 0;
    end
    always @(posedge sys_clk_in) begin
        if (rst_in || ready_out) begin
            ready_out <= 1'b0;
            // Inverted so a stale read never looks right
            rdata_out <= ~rdata_out;
            cnt <= 0;
        end else if (strobe_in && cnt < lat) begin
            cnt <= cnt + 1;
        end else if (strobe_in) begin
            ready_out <= 1'b1;
            lg[n_log] <= {lock_in, we_in, stat_in, addr_in, wdata_in};
            n_log <= n_log + 1;
            if (we_in)
                mem[addr_in[7:1]] <= wdata_in;
            else if (stat_in inside {ST_NMI_ACK, ST_NVI_ACK, ST_VI_ACK})
                rdata_out <= vec_val;
            else
                rdata_out <= mem[addr_in[7:1]];
        end
    end
endmodule

// ===== verilog/itss_bus_if.sv
`timescale 1ns/1ns
interface itss_bus_if;
    logic        req;
    logic        we;
    logic [3:0]  stat;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        done;
    modport master (output req, output we, output stat, output addr, output wdata,
                    input rdata, input done);
    modport port   (input req, input we, input stat, input addr, input wdata,
                    output rdata, output done);
endinterface

// ===== verilog/itss_bus_port.sv
`timescale 1ns/1ns
// Single outstanding transfer; external ready ends it and read data is captured
module itss_bus_port
    import itss_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    itss_bus_if.port         bus,
    input  wire logic        ext_ready_in,
    input  wire logic [15:0] ext_rdata_in,
    output logic             ext_strobe_out,
    output logic             ext_we_out,
    output logic [3:0]       ext_stat_out,
    output logic [15:0]      ext_addr_out,
    output logic [15:0]      ext_wdata_out
);
    logic        busy_ff, nxt_busy;
    logic [15:0] rd_ff, nxt_rd;
    logic        done_ff, nxt_done;

    always_comb begin
        nxt_busy = busy_ff;
        nxt_rd   = rd_ff;
        nxt_done = 1'b0;
        if (busy_ff && ext_ready_in) begin
            nxt_busy = 1'b0;
            nxt_rd   = ext_rdata_in;
            nxt_done = 1'b1;
        end else if (!busy_ff && bus.req && !done_ff) begin
            nxt_busy = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            busy_ff <= 1'b0;
            rd_ff   <= 16'h0000;
            done_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
            rd_ff   <= nxt_rd;
            done_ff <= nxt_done;
        end
    end

    assign bus.done       = done_ff;
    assign bus.rdata      = rd_ff;
    assign ext_strobe_out = busy_ff;
    assign ext_we_out     = busy_ff & bus.we;
    assign ext_stat_out   = busy_ff ? bus.stat : ST_IDLE;
    assign ext_addr_out   = busy_ff ? bus.addr : 16'h0000;
    assign ext_wdata_out  = busy_ff ? bus.wdata : 16'h0000;

    a_done_after_busy: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        done_ff |-> $past(busy_ff)) else $error("done without transfer");
endmodule

// ===== verilog/itss_pkg.sv
package itss_pkg;
    localparam int ADDR_W       = 16;
    localparam int SEG_W        = 7;
    localparam int LIN_W        = 23;
    localparam int VEC_W        = 16;
    localparam int PSW_FLAG_W   = 8;
    localparam int PSW_CTRL_W   = 8;
    localparam int PC_W         = 16;
    localparam int STAT_W       = 4;
    // Bus transaction status codes
    localparam logic [3:0] ST_IDLE     = 4'h0;
    localparam logic [3:0] ST_NMI_ACK  = 4'h5;
    localparam logic [3:0] ST_NVI_ACK  = 4'h6;
    localparam logic [3:0] ST_VI_ACK   = 4'h7;
    localparam logic [3:0] ST_STACK    = 4'h9;
    localparam logic [3:0] ST_DATA     = 4'h8;
    localparam logic [3:0] ST_EPU_DATA = 4'hA;
    // Control word bit positions
    localparam int CTL_SYS_BIT  = 6;
    localparam int CTL_VIE_BIT  = 4;
    localparam int CTL_NVIE_BIT = 3;
    // Reset values
    localparam logic [7:0]  CTL_RST   = 8'h40;
    localparam logic [15:0] PSAP_RST  = 16'h0000;
    localparam logic [15:0] SP_RST    = 16'h0000;
    // Offsets within the program status area, in bytes
    localparam logic [15:0] PSA_NMI_OFF   = 16'h0004;
    localparam logic [15:0] PSA_NVI_OFF   = 16'h0008;
    localparam logic [15:0] PSA_TRAP_OFF  = 16'h000C;
    localparam logic [15:0] PSA_SC_OFF    = 16'h0010;
    localparam logic [15:0] PSA_VI_OFF    = 16'h0014;
    localparam logic [15:0] PSA_JT_OFF    = 16'h0018;
    // Reason codes pushed for internal exceptions
    localparam logic [15:0] WHY_PRIV      = 16'h0001;
    localparam logic [15:0] WHY_SYSCALL   = 16'h0002;
    typedef enum logic [1:0] {ITSS_EXC_NONE, ITSS_EXC_PRIV, ITSS_EXC_SC} itss_exc_t;
endpackage

// ===== verilog/itss_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Three interrupt classes: NMI, NVI, VI
// - Push status and cause, then load new
// - Status is flags, control bits, PC
// - Read cause vector in acknowledge, push it
// - VI vector indexes jump table for routine
// - Privileged op in normal mode traps
// - System call loads new status; its control word sets the mode
// - Traps save status on system stack
// - Load program status replaces whole status
// - Test-and-set is one locked read-modify-write
// - Separate system and normal stack pointers
// - Extended opcode: do transfer, EXTENSION_PROCESSING_UNIT executes
// - 16-bit linear or 7+16 segmented address
// - First general register invalid stack pointer
// - Vectored wins over non-vectored
// - Status area located by pointer register
// - Output shows normal or system mode
module itss_top
    import itss_pkg::*;
#(
    parameter bit SEGMENTED = 1'b0
)(
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  nmi_req_in,
    input  wire logic                  nvi_req_in,
    input  wire logic                  vi_req_in,
    input  wire logic                  insn_end_in,
    input  wire logic                  priv_op_in,
    input  wire logic                  syscall_in,
    input  wire logic                  ldps_in,
    input  wire logic [15:0]           ldps_addr_in,
    input  wire logic                  tset_in,
    input  wire logic [15:0]           tset_addr_in,
    input  wire logic                  ext_op_in,
    input  wire logic                  ext_wr_in,
    input  wire logic [15:0]           ext_addr_in,
    input  wire logic [15:0]           ext_data_in,
    input  wire logic [3:0]            sp_reg_sel_in,
    input  wire logic [PSW_FLAG_W-1:0] cur_flags_in,
    input  wire logic [PC_W-1:0]       cur_pc_in,
    input  wire logic [SEG_W-1:0]      cur_seg_in,
    input  wire logic                  psap_wr_in,
    input  wire logic [15:0]           psap_data_in,
    input  wire logic                  bus_ready_in,
    input  wire logic [15:0]           bus_rdata_in,
    output logic                       bus_strobe_out,
    output logic                       bus_we_out,
    output logic [STAT_W-1:0]          bus_stat_out,
    output logic [LIN_W-1:0]           bus_addr_out,
    output logic [15:0]                bus_wdata_out,
    output logic                       bus_lock_out,
    output logic                       normal_mode_out,
    output logic                       busy_out,
    output logic                       sp_invalid_out,
    output logic                       tset_old_out,
    output logic                       ps_load_out,
    output logic [PSW_FLAG_W-1:0]      new_flags_out,
    output logic [PSW_CTRL_W-1:0]      ctrl_out,
    output logic [PC_W-1:0]            new_pc_out,
    output logic [15:0]                sp_out
);
    typedef enum logic [3:0] {
        S_IDLE, S_ACK, S_PUSH_PC, S_PUSH_PS, S_PUSH_WHY, S_LD_PS, S_LD_PC,
        S_LD_JT, S_TS_RD, S_TS_WR, S_EXT
    } itss_state_t;

    itss_bus_if bif();
    logic [15:0] port_addr;

    itss_bus_port u_port (
        .sys_clk_in     (sys_clk_in),
        .rst_in         (rst_in),
        .bus            (bif.port),
        .ext_ready_in   (bus_ready_in),
        .ext_rdata_in   (bus_rdata_in),
        .ext_strobe_out (bus_strobe_out),
        .ext_we_out     (bus_we_out),
        .ext_stat_out   (bus_stat_out),
        .ext_addr_out   (port_addr),
        .ext_wdata_out  (bus_wdata_out)
    );

    itss_state_t st_ff, nxt_st;
    logic [7:0]  ctl_ff, nxt_ctl;
    logic [7:0]  flg_ff, nxt_flg;
    logic [15:0] pc_ff, nxt_pc;
    logic [15:0] ssp_ff, nxt_ssp;
    logic [15:0] nsp_ff, nxt_nsp;
    logic [15:0] psap_ff, nxt_psap;
    logic [15:0] why_ff, nxt_why;
    logic [15:0] tbl_ff, nxt_tbl;
    logic [15:0] ps_base_ff, nxt_ps_base;
    logic        vec_ff, nxt_vec;
    logic        ld_ff, nxt_ld;
    logic        old_ff, nxt_old;
    logic        sys_mode;
    logic        req_go;

    // NMI cannot be masked; maskable classes obey their control enable
    assign sys_mode = ctl_ff[CTL_SYS_BIT];
    assign req_go   = insn_end_in && (nmi_req_in || (vi_req_in && ctl_ff[CTL_VIE_BIT])
                      || (nvi_req_in && ctl_ff[CTL_NVIE_BIT]));

    always_comb begin
        nxt_st      = st_ff;
        nxt_ctl     = ctl_ff;
        nxt_flg     = flg_ff;
        nxt_pc      = pc_ff;
        nxt_ssp     = ssp_ff;
        nxt_nsp     = nsp_ff;
        nxt_psap    = psap_wr_in && sys_mode ? psap_data_in : psap_ff;
        nxt_why     = why_ff;
        nxt_tbl     = tbl_ff;
        nxt_ps_base = ps_base_ff;
        nxt_vec     = vec_ff;
        nxt_ld      = 1'b0;
        nxt_old     = old_ff;
        bif.req     = 1'b0;
        bif.we      = 1'b0;
        bif.stat    = ST_IDLE;
        bif.addr    = 16'h0000;
        bif.wdata   = 16'h0000;
        case (st_ff)
            S_IDLE: begin
                nxt_flg = cur_flags_in;
                nxt_pc  = cur_pc_in;
                if (req_go) begin
                    nxt_st = S_ACK;
                end else if (syscall_in) begin
                    nxt_why     = WHY_SYSCALL;
                    nxt_ps_base = psap_ff + PSA_SC_OFF;
                    nxt_vec     = 1'b0;
                    nxt_st      = S_PUSH_PC;
                end else if (priv_op_in && !sys_mode) begin
                    nxt_why     = WHY_PRIV;
                    nxt_ps_base = psap_ff + PSA_TRAP_OFF;
                    nxt_vec     = 1'b0;
                    nxt_st      = S_PUSH_PC;
                end else if (ldps_in && sys_mode) begin
                    // A vectored flag left by an earlier interrupt must not pull in the table
                    nxt_vec     = 1'b0;
                    nxt_ps_base = ldps_addr_in;
                    nxt_st      = S_LD_PS;
                end else if (tset_in) begin
                    nxt_st = S_TS_RD;
                end else if (ext_op_in) begin
                    nxt_st = S_EXT;
                end
            end
            S_ACK: begin
                bif.req = 1'b1;
                if (nmi_req_in) begin
                    bif.stat    = ST_NMI_ACK;
                    nxt_ps_base = psap_ff + PSA_NMI_OFF;
                    nxt_vec     = 1'b0;
                end else if (vi_req_in && ctl_ff[CTL_VIE_BIT]) begin
                    bif.stat    = ST_VI_ACK;
                    nxt_ps_base = psap_ff + PSA_VI_OFF;
                    nxt_vec     = 1'b1;
                end else begin
                    bif.stat    = ST_NVI_ACK;
                    nxt_ps_base = psap_ff + PSA_NVI_OFF;
                    nxt_vec     = 1'b0;
                end
                if (bif.done) begin
                    nxt_why = bif.rdata;
                    nxt_st  = S_PUSH_PC;
                end
            end
            S_PUSH_PC, S_PUSH_PS, S_PUSH_WHY: begin
                // Always the system stack, whatever mode was running
                bif.req  = 1'b1;
                bif.we   = 1'b1;
                bif.stat = ST_STACK;
                bif.addr = ssp_ff - 16'h0002;
                bif.wdata = st_ff == S_PUSH_PC ? pc_ff :
                            st_ff == S_PUSH_PS ? {ctl_ff, flg_ff} : why_ff;
                if (bif.done) begin
                    nxt_ssp = ssp_ff - 16'h0002;
                    nxt_st  = st_ff == S_PUSH_PC ? S_PUSH_PS :
                              st_ff == S_PUSH_PS ? S_PUSH_WHY : S_LD_PS;
                end
            end
            S_LD_PS: begin
                bif.req  = 1'b1;
                bif.stat = ST_DATA;
                bif.addr = ps_base_ff;
                if (bif.done) begin
                    nxt_ctl = bif.rdata[15:8];
                    nxt_flg = bif.rdata[7:0];
                    nxt_st  = S_LD_PC;
                end
            end
            S_LD_PC: begin
                bif.req  = 1'b1;
                bif.stat = ST_DATA;
                bif.addr = ps_base_ff + 16'h0002;
                if (bif.done) begin
                    nxt_pc = bif.rdata;
                    nxt_tbl = psap_ff + PSA_JT_OFF + {why_ff[14:0], 1'b0};
                    nxt_st = vec_ff ? S_LD_JT : S_IDLE;
                    nxt_ld = !vec_ff;
                end
            end
            S_LD_JT: begin
                bif.req  = 1'b1;
                bif.stat = ST_DATA;
                bif.addr = tbl_ff;
                if (bif.done) begin
                    nxt_pc = bif.rdata;
                    nxt_ld = 1'b1;
                    nxt_st = S_IDLE;
                end
            end
            S_TS_RD: begin
                bif.req  = 1'b1;
                bif.stat = ST_DATA;
                bif.addr = tset_addr_in;
                if (bif.done) begin
                    nxt_old = bif.rdata[15];
                    nxt_st  = S_TS_WR;
                end
            end
            S_TS_WR: begin
                bif.req   = 1'b1;
                bif.we    = 1'b1;
                bif.stat  = ST_DATA;
                bif.addr  = tset_addr_in;
                bif.wdata = 16'hFFFF;
                if (bif.done) begin
                    nxt_st = S_IDLE;
                end
            end
            S_EXT: begin
                bif.req   = 1'b1;
                bif.we    = ext_wr_in;
                bif.stat  = ST_EPU_DATA;
                bif.addr  = ext_addr_in;
                bif.wdata = ext_data_in;
                if (bif.done) begin
                    nxt_st = S_IDLE;
                end
            end
            default: nxt_st = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_ff      <= S_IDLE;
            ctl_ff     <= CTL_RST;
            flg_ff     <= 8'h00;
            pc_ff      <= 16'h0000;
            ssp_ff     <= SP_RST;
            nsp_ff     <= SP_RST;
            psap_ff    <= PSAP_RST;
            why_ff     <= 16'h0000;
            tbl_ff     <= 16'h0000;
            ps_base_ff <= 16'h0000;
            vec_ff     <= 1'b0;
            ld_ff      <= 1'b0;
            old_ff     <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            ctl_ff     <= nxt_ctl;
            flg_ff     <= nxt_flg;
            pc_ff      <= nxt_pc;
            ssp_ff     <= nxt_ssp;
            nsp_ff     <= nxt_nsp;
            psap_ff    <= nxt_psap;
            why_ff     <= nxt_why;
            tbl_ff     <= nxt_tbl;
            ps_base_ff <= nxt_ps_base;
            vec_ff     <= nxt_vec;
            ld_ff      <= nxt_ld;
            old_ff     <= nxt_old;
        end
    end

    // Segment lines only exist on the segmented variant
    assign bus_addr_out    = SEGMENTED ? {cur_seg_in, port_addr} : {7'h00, port_addr};
    assign bus_lock_out    = (st_ff == S_TS_RD) || (st_ff == S_TS_WR);
    assign normal_mode_out = !sys_mode;
    assign sp_out          = sys_mode ? ssp_ff : nsp_ff;
    assign sp_invalid_out  = sp_reg_sel_in == 4'h0;
    assign busy_out        = st_ff != S_IDLE;
    assign tset_old_out    = old_ff;
    assign ps_load_out     = ld_ff;
    assign new_flags_out   = flg_ff;
    assign ctrl_out        = ctl_ff;
    assign new_pc_out      = pc_ff;

    a_vi_over_nvi: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_ff == S_ACK && !nmi_req_in && vi_req_in && ctl_ff[CTL_VIE_BIT])
        |-> bif.stat == ST_VI_ACK) else $error("vectored not first");
    a_push_sys_stack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (bif.req && bif.stat == ST_STACK) |-> bif.addr == ssp_ff - 16'h0002)
        else $error("push off system stack");
    a_nsp_untouched: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_ff != S_IDLE) |=> $stable(nsp_ff)) else $error("normal stack hit");
    a_priv_traps: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_ff == S_IDLE && !req_go && !syscall_in && priv_op_in && !sys_mode)
        |=> st_ff == S_PUSH_PC && why_ff == WHY_PRIV) else $error("no trap");
    a_mode_out: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        normal_mode_out != ctl_ff[CTL_SYS_BIT]) else $error("mode pin wrong");
    a_sp_select: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sp_out == (normal_mode_out ? nsp_ff : ssp_ff)) else $error("bad stack ptr");
    a_ts_atomic: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_ff == S_TS_RD && bif.done) |=> st_ff == S_TS_WR && bus_lock_out)
        else $error("tset split");
    a_ack_then_push: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (st_ff == S_ACK && bif.done) |=> st_ff == S_PUSH_PC && why_ff == $past(bif.rdata))
        else $error("vector not kept");
    a_r0_invalid: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sp_invalid_out == (sp_reg_sel_in == 4'h0)) else $error("sp check");
    a_nonseg_addr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !SEGMENTED |-> bus_addr_out[22:16] == 7'h00) else $error("seg bits set");

    c_vi_path: cover property (@(posedge sys_clk_in) st_ff == S_LD_JT && bif.done);
    c_syscall: cover property (@(posedge sys_clk_in) st_ff == S_IDLE && syscall_in);
    c_tset: cover property (@(posedge sys_clk_in) st_ff == S_TS_WR && bif.done);
    c_ext: cover property (@(posedge sys_clk_in) st_ff == S_EXT && bif.done);
endmodule
